// ==== hw/mas_mult_add.sv ====
`include "mas_regs.svh"

module mas_mult_add (
   // APB slave
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic [7:0]                    paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // Single-bit datapath controls
   input  wire logic                          ena,
   input  wire logic                          aclr,
   // Operand buses, multiplier i in slice i
   input  wire logic [`MAS_N*`MAS_OPW-1:0]    opa,
   input  wire logic [`MAS_N*`MAS_OPW-1:0]    opb,
   input  wire logic [`MAS_OPW-1:0]           shiftin_a,
   input  wire logic [`MAS_FULLW-1:0]         chainin,
   // Results
   output logic      [`MAS_OUTW-1:0]          result,
   output logic                               overflow,
   output logic      [`MAS_FULLW-1:0]         chainout,
   output logic      [`MAS_OPW-1:0]           shiftout_a
);
   localparam int N  = `MAS_N;
   localparam int OW = `MAS_OPW;
   localparam int IW = `MAS_INTW;

   // Register state
   logic [22:0]              ctrl_q, ctrl_d;
   logic                     pready_q, pready_d;
   logic                     pslverr_q, pslverr_d;
   logic [31:0]              prdata_q, prdata_d;
   logic [`MAS_OUTW-1:0]     res_q, res_d;
   logic                     ovf_q, ovf_d;
   logic [`MAS_FULLW-1:0]    chain_q, chain_d;
   logic [OW-1:0]            shout_q, shout_d;

   // Decoded options
   mas_pkg::mas_sat_t        sat_mode;
   mas_pkg::mas_rnd_t        rnd_mode;
   logic                     signed_mode;
   logic                     use_shin;
   logic                     acc_on;
   logic                     dp_ena;
   logic                     dp_clr;
   logic                     cfg_err;

   assign sat_mode    = mas_pkg::mas_sat_t'(ctrl_q[`MAS_CTRL_SAT +: 2]);
   assign rnd_mode    = mas_pkg::mas_rnd_t'(ctrl_q[`MAS_CTRL_RND +: 2]);
   assign signed_mode = ctrl_q[`MAS_CTRL_SIGNED];
   assign use_shin    = ctrl_q[`MAS_CTRL_SHIN];
   assign acc_on      = ctrl_q[`MAS_CTRL_ACC];
   // Enable pin only counts once software opts in
   assign dp_ena      = ~ctrl_q[`MAS_CTRL_USEENA] | ena;
   assign dp_clr      = ctrl_q[`MAS_CTRL_USECLR] & aclr;
   // Rounding in wrap mode is reported, not blocked
   assign cfg_err     = (rnd_mode != mas_pkg::MAS_RND_TRUNC) && (sat_mode == mas_pkg::MAS_SAT_WRAP);

   // APB: one wait state, so prdata and pready both leave flip-flops
   always_comb begin
      ctrl_d    = ctrl_q;
      pready_d  = psel & penable & ~pready_q;
      pslverr_d = 1'b0;
      prdata_d  = prdata_q;
      if (psel && penable && !pready_q) begin
         prdata_d = 32'h0000_0000;
         case (paddr)
            `MAS_OFS_CTRL:   prdata_d = {9'h000, ctrl_q};
            `MAS_OFS_STATUS: prdata_d = {28'h000_0000, acc_on | ctrl_q[`MAS_CTRL_RADD],
                                         use_shin | ctrl_q[`MAS_CTRL_RIN], cfg_err, ovf_q};
            `MAS_OFS_RESULT: prdata_d = res_q;
            default:         pslverr_d = 1'b1;
         endcase
      end
      if (psel && penable && pready_q) begin
         pslverr_d = pslverr_q;
         if (pwrite && paddr == `MAS_OFS_CTRL) begin
            ctrl_d = pwdata[22:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q    <= `MAS_CTRL_RST;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         ctrl_q    <= ctrl_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // Operand stage and multipliers
   logic [N*OW-1:0]            a_used;
   logic signed [2*OW+1:0]     prod   [N];
   logic [N*(2*OW+2)-1:0]      prod_flat;
   logic [N*(2*OW+2)-1:0]      prod_y;

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_mul
         mas_stage_if #(.W(2*OW)) in_if ();
         logic signed [OW:0] ea;
         logic signed [OW:0] eb;

         // Shift-in chains each later a operand from the previous input register, the first from shiftin_a
         if (gi == 0) begin : g_first
            assign in_if.d[2*OW-1:OW] = use_shin ? shiftin_a : opa[OW-1:0];
         end else begin : g_next
            assign in_if.d[2*OW-1:OW] = use_shin ? a_used[(gi-1)*OW +: OW] : opa[gi*OW +: OW];
         end
         assign in_if.d[OW-1:0] = opb[gi*OW +: OW];
         assign in_if.use_reg   = ctrl_q[`MAS_CTRL_RIN] | use_shin;

         mas_pipe_stage #(.W(2*OW)) u_in (
            .clk   (pclk),
            .rst_n (presetn),
            .clr   (dp_clr),
            .ena   (dp_ena),
            .s     (in_if)
         );

         assign a_used[gi*OW +: OW] = in_if.y[2*OW-1:OW];
         // Sign bit only in signed mode, zero extension otherwise
         assign ea = {signed_mode & in_if.y[2*OW-1], in_if.y[2*OW-1:OW]};
         assign eb = {signed_mode & in_if.y[OW-1], in_if.y[OW-1:0]};
         assign prod[gi] = ea * eb;
         assign prod_flat[gi*(2*OW+2) +: 2*OW+2] = prod[gi];
      end
   endgenerate

   // Product register for all multipliers at once
   mas_stage_if #(.W(N*(2*OW+2))) prod_if ();
   assign prod_if.d       = prod_flat;
   assign prod_if.use_reg = ctrl_q[`MAS_CTRL_RPROD];
   assign prod_y          = prod_if.y;

   mas_pipe_stage #(.W(N*(2*OW+2))) u_prod (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (dp_clr),
      .ena   (dp_ena),
      .s     (prod_if)
   );

   // Adder tree: pairs (0,1) and (2,3) each add or subtract
   logic signed [IW-1:0] sum;
   logic signed [IW-1:0] pp [N];
   mas_stage_if #(.W(IW)) add_if ();

   always_comb begin
      for (int i = 0; i < N; i++) begin
         pp[i] = IW'($signed(prod_y[i*(2*OW+2) +: 2*OW+2]));
      end
      sum = '0;
      for (int i = 0; i < N; i++) begin
         if ((i < 2 && ctrl_q[`MAS_CTRL_SUB1]) || (i >= 2 && ctrl_q[`MAS_CTRL_SUB2])) begin
            sum = sum - pp[i];
         end else begin
            sum = sum + pp[i];
         end
      end
   end

   // Accumulator feeds back through the adder register
   always_comb begin
      if (!acc_on) begin
         add_if.d = sum;
      end else if (ctrl_q[`MAS_CTRL_ACCSUB]) begin
         add_if.d = add_if.y - sum;
      end else begin
         add_if.d = add_if.y + sum;
      end
   end
   assign add_if.use_reg = ctrl_q[`MAS_CTRL_RADD] | acc_on;

   mas_pipe_stage #(.W(IW)) u_add (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (dp_clr),
      .ena   (dp_ena),
      .s     (add_if)
   );

   // Chain-sum adder; the upstream stage must drive chainin when MAS_CTRL_CHIN is set
   mas_stage_if #(.W(IW)) chn_if ();
   always_comb begin
      if (ctrl_q[`MAS_CTRL_CHIN]) begin
         chn_if.d = add_if.y + IW'($signed(chainin));
      end else begin
         chn_if.d = add_if.y;
      end
   end
   assign chn_if.use_reg = ctrl_q[`MAS_CTRL_RCHAIN];

   mas_pipe_stage #(.W(IW)) u_chn (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (dp_clr),
      .ena   (dp_ena),
      .s     (chn_if)
   );

   // Cascade shift output taken from the last multiplier's a operand
   mas_stage_if #(.W(OW)) sho_if ();
   assign sho_if.d       = a_used[(N-1)*OW +: OW];
   assign sho_if.use_reg = ctrl_q[`MAS_CTRL_RSHOUT];

   mas_pipe_stage #(.W(OW)) u_sho (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (dp_clr),
      .ena   (dp_ena),
      .s     (sho_if)
   );

   // Rounding and saturation of the chain-sum value
   logic [3:0]           shamt;
   logic signed [IW:0]   v;
   logic signed [IW:0]   half;
   logic signed [IW:0]   tv;
   logic signed [IW:0]   bias;
   logic signed [IW:0]   biased;
   logic signed [IW:0]   rnd;
   logic signed [IW:0]   hi;
   logic signed [IW:0]   lo;

   always_comb begin
      shamt = ctrl_q[`MAS_CTRL_SHIFT +: 4];
      v     = {chn_if.y[IW-1], chn_if.y};
      half  = (shamt == 4'h0) ? '0 : ((IW+1)'(1) <<< (shamt - 4'h1));
      tv    = v >>> shamt;
      // Ties go up for nearest, to the even neighbour for MAS_RND_EVEN
      case (rnd_mode)
         mas_pkg::MAS_RND_NEAR: bias = half;
         mas_pkg::MAS_RND_EVEN: bias = (shamt == 4'h0) ? '0 : half - (IW+1)'(1) + (IW+1)'(tv[0]);
         default:               bias = '0;
      endcase
      biased = v + bias;
      rnd    = biased >>> shamt;
      // Limits: symmetric mirrors the positive maximum
      if (!signed_mode) begin
         hi = `MAS_UMAX;
         lo = `MAS_UMIN;
      end else if (sat_mode == mas_pkg::MAS_SAT_SYM) begin
         hi = `MAS_SMAX;
         lo = `MAS_SMIN_SYM;
      end else begin
         hi = `MAS_SMAX;
         lo = `MAS_SMIN_ASYM;
      end
      // Wrap simply drops the high bits
      res_d = rnd[`MAS_OUTW-1:0];
      ovf_d = 1'b0;
      if (sat_mode == mas_pkg::MAS_SAT_SYM || sat_mode == mas_pkg::MAS_SAT_ASYM) begin
         if (rnd > hi) begin
            res_d = hi[`MAS_OUTW-1:0];
            ovf_d = ctrl_q[`MAS_CTRL_OVFEN];
         end else if (rnd < lo) begin
            res_d = lo[`MAS_OUTW-1:0];
            ovf_d = ctrl_q[`MAS_CTRL_OVFEN];
         end
      end
      chain_d = chn_if.y[`MAS_FULLW-1:0];
      shout_d = sho_if.y;
      if (!dp_ena) begin
         res_d   = res_q;
         ovf_d   = ovf_q;
         chain_d = chain_q;
         shout_d = shout_q;
      end
   end

   // Output flops: flag and clamped value load on the same edge
   always_ff @(posedge pclk or negedge presetn or posedge dp_clr) begin
      if (!presetn) begin
         res_q   <= '0;
         ovf_q   <= 1'b0;
         chain_q <= '0;
         shout_q <= '0;
      end else if (dp_clr) begin
         res_q   <= '0;
         ovf_q   <= 1'b0;
         chain_q <= '0;
         shout_q <= '0;
      end else begin
         res_q   <= res_d;
         ovf_q   <= ovf_d;
         chain_q <= chain_d;
         shout_q <= shout_d;
      end
   end

   assign result     = res_q;
   assign overflow   = ovf_q;
   assign chainout   = chain_q;
   assign shiftout_a = shout_q;
endmodule : mas_mult_add

// ==== hw/mas_regs.svh ====
`ifndef MAS_REGS_SVH
`define MAS_REGS_SVH

// Datapath geometry
`define MAS_N          4
`define MAS_OPW        18
`define MAS_LOGN       2
`define MAS_FULLW      38
`define MAS_INTW       40
`define MAS_OUTW       32

// Register byte offsets and control reset value
`define MAS_OFS_CTRL   8'h00
`define MAS_OFS_STATUS 8'h04
`define MAS_OFS_RESULT 8'h08
`define MAS_CTRL_RST   23'h00_0000

// Control field positions
`define MAS_CTRL_SAT    0
`define MAS_CTRL_RND    2
`define MAS_CTRL_OVFEN  4
`define MAS_CTRL_SIGNED 5
`define MAS_CTRL_RIN    6
`define MAS_CTRL_RPROD  7
`define MAS_CTRL_RADD   8
`define MAS_CTRL_RCHAIN 9
`define MAS_CTRL_RSHOUT 10
`define MAS_CTRL_ACC    11
`define MAS_CTRL_SHIN   12
`define MAS_CTRL_CHIN   13
`define MAS_CTRL_SUB1   14
`define MAS_CTRL_SUB2   15
`define MAS_CTRL_ACCSUB 16
`define MAS_CTRL_SHIFT  17
`define MAS_CTRL_USEENA 21
`define MAS_CTRL_USECLR 22

// Clamp limits on the 41-bit rounded value
`define MAS_SMAX      41'h000_7fff_ffff
`define MAS_SMIN_SYM  41'h1ff_8000_0001
`define MAS_SMIN_ASYM 41'h1ff_8000_0000
`define MAS_UMAX      41'h000_ffff_ffff
`define MAS_UMIN      41'h000_0000_0000

`endif

// ==== hw/mas_pkg.sv ====
package mas_pkg;
   // Overflow treatment of the output stage
   typedef enum logic [1:0] {
      MAS_SAT_WRAP = 2'b00,
      MAS_SAT_SYM  = 2'b01,
      MAS_SAT_ASYM = 2'b10,
      MAS_SAT_RSVD = 2'b11
   } mas_sat_t;

   // Reduction of low result bits
   typedef enum logic [1:0] {
      MAS_RND_TRUNC = 2'b00,
      MAS_RND_NEAR  = 2'b01,
      MAS_RND_EVEN  = 2'b10,
      MAS_RND_RSVD  = 2'b11
   } mas_rnd_t;
endpackage : mas_pkg

// ==== hw/mas_stage_if.sv ====
interface mas_stage_if #(parameter int W = 8) ();
   logic         use_reg;
   logic [W-1:0] d;
   logic [W-1:0] y;
   modport stage (input use_reg, input d, output y);
   modport feed  (output use_reg, output d, input y);
endinterface : mas_stage_if

// ==== hw/mas_pipe_stage.sv ====
// Bypassable pipeline register of the datapath
module mas_pipe_stage #(parameter int W = 8) (
   // Clock, clears and enable
   input wire logic   clk,
   input wire logic   rst_n,
   input wire logic   clr,
   input wire logic   ena,
   // Data
   mas_stage_if.stage s
);
   logic [W-1:0] q_q;
   logic [W-1:0] q_d;

   // Holds while the enable is low
   always_comb begin
      q_d = ena ? s.d : q_q;
   end

   // Clear wins over the clock
   always_ff @(posedge clk or negedge rst_n or posedge clr) begin
      if (!rst_n) begin
         q_q <= '0;
      end else if (clr) begin
         q_q <= '0;
      end else begin
         q_q <= q_d;
      end
   end

   // Bypass keeps the stage zero-latency when not selected
   assign s.y = s.use_reg ? q_q : s.d;
endmodule : mas_pipe_stage

// ==== test/mas_chk.sv ====
`include "mas_regs.svh"

module mas_chk (
   // APB side
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic [7:0]                 paddr,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [31:0]                pwdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   // Datapath side
   input wire logic                       ena,
   input wire logic                       aclr,
   input wire logic [`MAS_N*`MAS_OPW-1:0] opa,
   input wire logic [`MAS_OUTW-1:0]       result,
   input wire logic                       overflow,
   input wire logic [`MAS_FULLW-1:0]      chainout,
   input wire logic [`MAS_OPW-1:0]        shiftout_a
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [22:0]         ctrl_q;
   logic [22:0]         ctrl_d;
   logic                no_ovf;
   logic                sym_on;
   logic                sh_plain;
   logic [`MAS_OPW-1:0] op3;

   // Mirror of the control word, since only the ports are visible here
   always_comb ctrl_d = (psel && penable && pready && pwrite && paddr == `MAS_OFS_CTRL) ? pwdata[22:0] : ctrl_q;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ctrl_q <= 23'h00_0000;
      else
         ctrl_q <= ctrl_d;

   // Modes of interest; a held pipeline would keep stale flags, so enable use is excluded
   assign no_ovf   = (!ctrl_q[4] || ctrl_q[1:0] == 2'h0 || ctrl_q[1:0] == 2'h3) && !ctrl_q[21];
   assign sym_on   = ctrl_q[1:0] == 2'h1 && ctrl_q[5] && !ctrl_q[21];
   assign sh_plain = !ctrl_q[6] && !ctrl_q[10] && !ctrl_q[12] && !ctrl_q[21] && !ctrl_q[22];
   assign op3      = opa[`MAS_N*`MAS_OPW-1 -: `MAS_OPW];

   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);

   apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   apb_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   apb_err_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
      else $error("pslverr does not match address map");
   ovf_clamp_a: assert property (overflow |-> result inside {32'h7fff_ffff, 32'h8000_0001,
      32'h8000_0000, 32'hffff_ffff, 32'h0000_0000})
      else $error("overflow without a clamp value");
   ovf_quiet_a: assert property ($past(no_ovf) && no_ovf |-> !overflow)
      else $error("overflow raised with flagging off");
   sym_floor_a: assert property ($past(sym_on) && sym_on |-> result != 32'h8000_0000)
      else $error("symmetric clamp reached full negative");
   ena_hold_a: assert property (ctrl_q[21] && !ctrl_q[22] && !ena |=>
      $stable(result) && $stable(overflow) && $stable(shiftout_a))
      else $error("outputs moved with enable low");
   clr_zero_a: assert property (ctrl_q[22] && aclr |-> result == 32'h0 && chainout == 38'h0 && !overflow)
      else $error("clear did not zero outputs");
   shift_pass_a: assert property ($past(sh_plain) && sh_plain && $past(presetn) |-> shiftout_a == $past(op3))
      else $error("shift output not one cycle behind");
endmodule : mas_chk

bind mas_mult_add mas_chk i_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .ena(ena), .aclr(aclr), .opa(opa), .result(result), .overflow(overflow), .chainout(chainout),
   .shiftout_a(shiftout_a));

// ==== test/mas_src_model.sv ====
`include "mas_regs.svh"

module mas_src_model (
   // Values chosen by the test
   input wire logic [`MAS_OPW-1:0]   a,
   input wire logic [`MAS_OPW-1:0]   b,
   input wire logic [`MAS_FULLW-1:0] prev,
   // Buses into the block
   output logic [`MAS_N*`MAS_OPW-1:0] opa,
   output logic [`MAS_N*`MAS_OPW-1:0] opb,
   output logic [`MAS_OPW-1:0]        shiftin_a,
   output logic [`MAS_FULLW-1:0]      chainin
);
   timeunit 1ns;
   timeprecision 100ps;

   // All four multipliers share one 18-bit pair, so the sum is four equal products
   assign opa = {`MAS_N{a}};
   assign opb = {`MAS_N{b}};
   // Upstream neighbour hands its own a operand down the shift chain
   assign shiftin_a = a;
   // Chain input carries only the previous stage's chain sum
   assign chainin = prev;
endmodule : mas_src_model

// ==== test/mas_mult_add_tb.sv ====
`include "mas_regs.svh"

module mas_mult_add_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic                       pclk;
   logic                       presetn;
   logic                       psel;
   logic                       penable;
   logic                       pwrite;
   logic                       ena;
   logic                       aclr;
   logic                       err;
   logic                       pready;
   logic                       pslverr;
   logic                       overflow;
   logic [7:0]                 paddr;
   logic [31:0]                pwdata;
   logic [31:0]                prdata;
   logic [31:0]                rd;
   logic [`MAS_OPW-1:0]        a;
   logic [`MAS_OPW-1:0]        b;
   logic [`MAS_OPW-1:0]        shiftin_a;
   logic [`MAS_OPW-1:0]        shiftout_a;
   logic [`MAS_N*`MAS_OPW-1:0] opa;
   logic [`MAS_N*`MAS_OPW-1:0] opb;
   logic [`MAS_FULLW-1:0]      prev;
   logic [`MAS_FULLW-1:0]      chainin;
   logic [`MAS_FULLW-1:0]      chainout;
   logic [`MAS_OUTW-1:0]       result;
   logic [32:0]                e;
   logic [17:0]                bv [2] = '{18'h2_0000, 18'h1_ffff};
   logic [31:0]                rx [3] = '{32'h2, 32'h3, 32'h2};
   logic [31:0]                lc [5] = '{32'h20, 32'ha0, 32'h3e0, 32'h460, 32'h1020};
   int                         lr [5] = '{1, 2, 5, 2, 5};
   int                         ls [5] = '{1, 1, 2, 3, 5};
   int                         kr;
   int                         ks;
   int                         num_errors = 0;
   int                         checks = 0;

   mas_mult_add i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ena(ena),
      .aclr(aclr), .opa(opa), .opb(opb), .shiftin_a(shiftin_a), .chainin(chainin), .result(result),
      .overflow(overflow), .chainout(chainout), .shiftout_a(shiftout_a));
   mas_src_model i_src (.a(a), .b(b), .prev(prev), .opa(opa), .opb(opb), .shiftin_a(shiftin_a),
      .chainin(chainin));

   // Clock at 200 MHz
   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;

   // Compare one value and count it
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp

   // Print the counts and the verdict, then stop
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick

   // One APB transfer, held until pready is sampled high; a lost answer ends the run
   task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] wd);
      int n;
      psel   <= 1'b1;
      paddr  <= ad;
      pwrite <= w;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Set the mode and operands, let every stage settle, check the output
   task automatic feed(input logic [31:0] c, input logic [17:0] va, input logic [17:0] vb,
                       input logic [31:0] er, input logic eo);
      apb(`MAS_OFS_CTRL, 1'b1, c);
      a <= va;
      b <= vb;
      tick(8);
      cmp(result, er);
      cmp(overflow, eo);
   endtask : feed

   // Clamp stage outcome for four equal signed products, flag in the top bit
   function automatic logic [32:0] clamp(input logic [1:0] m, input logic signed [17:0] x,
                                         input logic signed [17:0] y);
      longint s;
      longint hi;
      longint lo;
      s = 4 * longint'(x) * longint'(y);
      hi = 64'sh7fff_ffff;
      lo = (m == 2'h2) ? -hi - 1 : -hi;
      if (m inside {2'h1, 2'h2} && s > hi)
         return {1'b1, hi[31:0]};
      if (m inside {2'h1, 2'h2} && s < lo)
         return {1'b1, lo[31:0]};
      return {1'b0, s[31:0]};
   endfunction : clamp

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, aclr, paddr, pwdata} = 44'h0;
      {a, b, prev} = 74'h0;
      ena = 1'b1;
      tick(2);
      presetn <= 1'b1;
      apb(`MAS_OFS_CTRL, 1'b0, 32'h0);
      cmp(rd, 32'h0);
      cmp(err, 1'b0);
      apb(`MAS_OFS_CTRL, 1'b1, 32'hffff_ffff);
      apb(`MAS_OFS_CTRL, 1'b0, 32'h0);
      cmp(rd, 32'h007f_ffff);
      apb(8'h0c, 1'b0, 32'h0);
      cmp(err, 1'b1);
      $display("test registers done");
      // Largest positive and negative sums under every overflow mode
      for (int m = 0; m < 4; m++) begin
         foreach (bv[i]) begin
            e = clamp(m[1:0], 18'h2_0000, bv[i]);
            feed(32'h30 | m, 18'h2_0000, bv[i], e[31:0], e[32]);
         end
      end
      // Unsigned clamp to the top, then status and result as software sees them
      feed(32'h11, 18'h3_ffff, 18'h3_ffff, 32'hffff_ffff, 1'b1);
      apb(`MAS_OFS_STATUS, 1'b0, 32'h0);
      cmp(rd, 32'h1);
      apb(`MAS_OFS_RESULT, 1'b0, 32'h0);
      cmp(rd, 32'hffff_ffff);
      // Both pairs subtract, so the wrapped sum goes negative
      feed(32'hc020, 18'h3, 18'h5, 32'hffff_ffc4, 1'b0);
      $display("test saturation done");
      // A sum of 20 shifted right by 3 sits exactly on a half; saturation stays on
      for (int r = 0; r < 3; r++)
         feed(32'h6_0021 | (r << 2), 18'h5, 18'h1, rx[r], 1'b0);
      $display("test rounding done");
      // Count edges until a new operand reaches the result and the shift output
      foreach (lc[i]) begin
         feed(lc[i], 18'h3, 18'h5, 32'h3c, 1'b0);
         a <= 18'h7;
         kr = 0;
         ks = 0;
         for (int k = 1; k < 9; k++) begin
            @(posedge pclk);
            #1;
            if (kr == 0 && result === 32'h8c)
               kr = k;
            if (ks == 0 && shiftout_a === 18'h7)
               ks = k;
         end
         cmp(kr, lr[i]);
         cmp(ks, ls[i]);
         @(posedge pclk);
      end
      $display("test latency done");
      ena <= 1'b0;
      feed(32'h20_0020, 18'h3, 18'h5, 32'h8c, 1'b0);
      ena <= 1'b1;
      feed(32'h20_0020, 18'h3, 18'h5, 32'h3c, 1'b0);
      aclr <= 1'b1;
      feed(32'h40_0020, 18'h3, 18'h5, 32'h0, 1'b0);
      cmp(chainout, 38'h0);
      // Accumulator starts from the cleared register and adds 60 per edge
      feed(32'h40_0820, 18'h3, 18'h5, 32'h0, 1'b0);
      aclr <= 1'b0;
      tick(4);
      cmp(result, 32'h78);
      prev <= 38'h3e8;
      feed(32'h2020, 18'h3, 18'h5, 32'h424, 1'b0);
      cmp(chainout, 38'h424);
      $display("test enable clear chain done");
      tally_and_finish();
   end
endmodule : mas_mult_add_tb
